// ===== src/accum_shift_store_datapath.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "acc_dp_consts.svh"
// Functional notes
// [RQ1] Truncating store leaves the source accumulator unchanged.
// [RQ2] Truncating store writes shifted high word, low bits discarded.
// [RQ3] Rounding store rounds shifted high word using lower bits.
// [RQ4] Rounding is conventional or convergent per control bit 1.
// [RQ5] Control bit 5 saturates stored word after the pre-shift.
// [RQ6] Accumulator shift arithmetically shifts all 40 bits in place.
// [RQ7] Register shift uses only six low bits of count register.
// [RQ8] Shift amount -16..16; negative left, positive right arithmetic.
// [RQ9] Bits shifted out of the accumulator are lost.
// [RQ10] Out-of-range shift leaves accumulator unmodified.
// [RQ11] One instruction bit selects accumulator A or B.
// [RQ12] Sign extend copies byte bit 7 into upper eight bits.
// [RQ13] Sign extend updates N and Z, C equals inverse of N.
// [RQ14] Sign extend source direct or indirect; destination direct register.
// [RQ15] Store pre-shift literal -8..7, negative left, positive right.
// [RQ16] Stores write accumulator bits 31:16 after shift.
// [RQ17] Set-all-ones writes ones to byte or word, flags unchanged.
// [RQ18] Shift saturates per accumulator enable and updates OV/SAT flags.
module accum_shift_store_datapath (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] ctrl;
	logic [39:0] accum_a;
	logic [39:0] accum_b;
	logic [15:0] oper;
	logic [15:0] result;
	logic flag_n, flag_z, flag_c, flag_oa, flag_ob, flag_sa, flag_sb, done;
	logic [7:0] cmd;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// ****************************************
	// Command decode
	// ****************************************
	// cmd[2:0] op, cmd[3] acc select, cmd[4] byte mode, cmd[7:4] short literal
	wire acc_dp_pkg::op_t op = acc_dp_pkg::op_t'(cmd[2:0]);
	wire logic sel_b = cmd[3]; // [RQ11]
	wire logic signed [3:0] short_shift_lit = cmd[7:4];
	wire logic [39:0] acc_src = sel_b ? accum_b : accum_a; // [RQ11]
	wire logic signed [6:0] acc_shift_lit = oper[6:0];
	wire logic [5:0] shift_count_reg = oper[5:0]; // [RQ7]
	wire logic signed [6:0] shift_amt = (op == acc_dp_pkg::op_shift_reg) ?
		7'({shift_count_reg[5], shift_count_reg}) : acc_shift_lit; // [RQ7]
	wire logic signed [6:0] store_amt = 7'(short_shift_lit); // [RQ15]
	wire logic store_op = (op == acc_dp_pkg::op_store_trunc) || (op == acc_dp_pkg::op_store_round);
	wire logic [39:0] shifted;
	wire logic amt_ok;
	acc_shifter u_shift (
		.acc_in(acc_src),
		.amount(store_op ? store_amt : shift_amt),
		.acc_out(shifted),
		.in_range(amt_ok)
	);
	// ****************************************
	// Store path
	// ****************************************
	function automatic logic [15:0] sat16(input logic [39:0] v);
		if (v[39:31] != {9{v[39]}})
			sat16 = v[39] ? 16'h8000 : 16'h7FFF;
		else
			sat16 = v[31:16];
	endfunction
	wire logic conv_rnd = ctrl[`BIT_RND]; // [RQ4]
	wire logic half_up = shifted[15] && (conv_rnd ? 1'b1 : ((shifted[14:0] != 15'h0000) || shifted[16]));
	wire logic [39:0] rounded = shifted + {23'h0, half_up, 16'h0000}; // [RQ3] [RQ4]
	wire logic [39:0] store_val = (op == acc_dp_pkg::op_store_round) ? rounded : shifted; // [RQ2]
	wire logic [15:0] store_word = ctrl[`BIT_DATA_WRITE_SAT_ENABLE] ? sat16(store_val) : store_val[31:16]; // [RQ5] [RQ16]
	// ****************************************
	// Shift saturation
	// ****************************************
	wire logic acc_sat_en = sel_b ? ctrl[`BIT_ACC_B_SAT_ENABLE] : ctrl[`BIT_ACC_A_SAT_ENABLE]; // [RQ18]
	wire logic ovf31 = shifted[39:31] != {9{shifted[39]}};
	wire logic [39:0] sat_acc = shifted[39] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF;
	wire logic [39:0] next_acc = (acc_sat_en && ovf31) ? sat_acc : shifted; // [RQ18]
	wire logic ov_flag = shifted[39:31] != {9{shifted[39]}}; // [RQ18]
	// ****************************************
	// Sign extend and set-all-ones
	// ****************************************
	wire logic [15:0] sext = {{8{oper[7]}}, oper[7:0]}; // [RQ12] [RQ14]
	wire logic [15:0] ones = cmd[4] ? {result[15:8], 8'hFF} : 16'hFFFF; // [RQ17]
	// ****************************************
	// AXI decode
	// ****************************************
	wire logic do_write = aw_held && w_held && !s_axi_bvalid;
	wire logic [15:0] wlo = w_data[15:0];
	wire logic wr_ctrl = do_write && aw_addr == `REG_CTRL;
	wire logic wr_cmd = do_write && aw_addr == `REG_CMD;
	wire logic exec = wr_cmd;
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= `REG_STATUS) && (a[1:0] == 2'b00);
	endfunction
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire logic [31:0] status_word = {24'h0, done, flag_sb, flag_sa, flag_ob, flag_oa, flag_c, flag_z, flag_n};
	logic [31:0] rd_mux;
	always_comb begin
		case (s_axi_araddr)
			`REG_CTRL: rd_mux = {16'h0, ctrl};
			`REG_ACC_A_LO: rd_mux = accum_a[31:0];
			`REG_ACC_A_HI: rd_mux = {24'h0, accum_a[39:32]};
			`REG_ACC_B_LO: rd_mux = accum_b[31:0];
			`REG_ACC_B_HI: rd_mux = {24'h0, accum_b[39:32]};
			`REG_OPER: rd_mux = {16'h0, oper};
			`REG_CMD: rd_mux = {24'h0, cmd};
			`REG_RESULT: rd_mux = {16'h0, result};
			`REG_STATUS: rd_mux = status_word;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	// ****************************************
	// Bus handshake
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ****************************************
	// Datapath state
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl <= `CTRL_RESET;
			accum_a <= 40'h00_0000_0000;
			accum_b <= 40'h00_0000_0000;
			oper <= 16'h0000;
			cmd <= 8'h00;
			result <= 16'h0000;
			{flag_n, flag_z, flag_c, flag_oa, flag_ob, flag_sa, flag_sb} <= 7'h00;
			done <= 1'b0;
		end else begin
			done <= exec;
			if (wr_ctrl && w_strb[0])
				ctrl <= wlo & `CTRL_MASK;
			if (do_write && w_strb[0] && aw_addr == `REG_ACC_A_LO)
				accum_a[31:0] <= w_data;
			if (do_write && w_strb[0] && aw_addr == `REG_ACC_A_HI)
				accum_a[39:32] <= w_data[7:0];
			if (do_write && w_strb[0] && aw_addr == `REG_ACC_B_LO)
				accum_b[31:0] <= w_data;
			if (do_write && w_strb[0] && aw_addr == `REG_ACC_B_HI)
				accum_b[39:32] <= w_data[7:0];
			if (do_write && aw_addr == `REG_OPER)
				oper <= wlo;
			if (wr_cmd)
				cmd <= w_data[7:0];
			if (done) begin
				case (op)
					acc_dp_pkg::op_store_trunc, acc_dp_pkg::op_store_round: begin
						result <= store_word; // [RQ1] [RQ2]
					end
					acc_dp_pkg::op_shift_lit, acc_dp_pkg::op_shift_reg: begin
						if (amt_ok) begin // [RQ10]
							if (sel_b) begin
								accum_b <= next_acc; // [RQ6]
								flag_ob <= ov_flag;
								flag_sb <= flag_sb | (acc_sat_en && ov_flag);
							end else begin
								accum_a <= next_acc; // [RQ6]
								flag_oa <= ov_flag;
								flag_sa <= flag_sa | (acc_sat_en && ov_flag);
							end
						end
					end
					acc_dp_pkg::op_sign_ext: begin
						result <= sext;
						flag_n <= sext[15]; // [RQ13]
						flag_z <= sext == 16'h0000;
						flag_c <= ~sext[15];
					end
					acc_dp_pkg::op_set_ones: begin
						result <= ones; // [RQ17]
					end
					default: begin
						result <= result;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/acc_dp_consts.svh
`ifndef ACC_DP_CONSTS_SVH
`define ACC_DP_CONSTS_SVH
// ****************************************
// Offsets and fields
// ****************************************
`define REG_CTRL 8'h00
`define REG_ACC_A_LO 8'h04
`define REG_ACC_A_HI 8'h08
`define REG_ACC_B_LO 8'h0C
`define REG_ACC_B_HI 8'h10
`define REG_OPER 8'h14
`define REG_CMD 8'h18
`define REG_RESULT 8'h1C
`define REG_STATUS 8'h20
`define BIT_RND 1
`define BIT_DATA_WRITE_SAT_ENABLE 5
`define BIT_ACC_B_SAT_ENABLE 6
`define BIT_ACC_A_SAT_ENABLE 7
`define CTRL_RESET 16'h0000
`define CTRL_MASK 16'h00E2
`define SLIT_MAX 16
`define SHORT_MIN -8
`define SHORT_MAX 7
`endif

// ===== src/acc_dp_pkg.sv
package acc_dp_pkg;
	typedef enum logic [2:0] {
		op_store_trunc = 3'b000,
		op_store_round = 3'b001,
		op_shift_lit = 3'b010,
		op_shift_reg = 3'b011,
		op_sign_ext = 3'b100,
		op_set_ones = 3'b101
	} op_t;
	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_done = 1'b1
	} state_t;
endpackage

// ===== src/acc_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_dp_consts.svh"
// ****************************************
// Arithmetic 40-bit shifter, amount -16..16
// ****************************************
module acc_shifter (
	input wire logic [39:0] acc_in,
	input wire logic signed [6:0] amount,
	output logic [39:0] acc_out,
	output logic in_range
);
	wire logic signed [39:0] src = acc_in;
	wire logic [5:0] mag = amount[6] ? 6'(-amount) : amount[5:0];
	assign in_range = (amount <= $signed(7'(`SLIT_MAX))) && (amount >= -$signed(7'(`SLIT_MAX)));
	// Bits leaving either end are dropped [RQ9]
	assign acc_out = !in_range ? acc_in : amount[6] ? (acc_in << mag) : 40'(src >>> mag); // [RQ8]
endmodule
`default_nettype wire

// ===== tb/acc_dp_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Register bus checks
// ****************************************
module acc_dp_props (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready && !s_axi_rvalid
		|=> s_axi_rvalid) else $error("read answer late");
	a_r_cause: assert property ($rose(s_axi_rvalid)
		|-> $past(s_axi_arvalid && s_axi_arready)) else $error("read answer unasked");
	a_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready
		|| s_axi_wvalid && s_axi_wready, 2)) else $error("write answer unasked");
	a_resp_codes: assert property (s_axi_bvalid
		|-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10) else $error("bad bresp");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10
		|-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
	a_reset_idle: assert property ($past(reset) |-> !s_axi_bvalid && !s_axi_rvalid
		&& s_axi_awready && s_axi_arready) else $error("bus not idle after reset");
endmodule
bind accum_shift_store_datapath acc_dp_props i_acc_dp_props (.*);
`default_nettype wire

// ===== tb/test_accum_shift_store_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_dp_consts.svh"
// ****************************************
// Datapath bench
// ****************************************
module test_accum_shift_store_datapath;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [39:0] acc;
		logic [15:0] oper;
		logic [7:0] cmd;
		logic [15:0] res;
		logic [39:0] acc_exp;
		logic [2:0] st;
		logic [1:0] chk;
	} row_t;
	logic core_clk = 1'b0, reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, q, lo;
	int bad_count = 0, samples_checked = 0;
	row_t rw;
	row_t rows [13] = '{
		'{8'h20,40'hff_c891_8f4c,16'h0000,8'hc8,16'h8000,40'hff_c891_8f4c,3'h0,2'h1},
		'{8'h22,40'hff_f891_8f4c,16'h0000,8'hc9,16'h8919,40'hff_f891_8f4c,3'h0,2'h1},
		'{8'h00,40'h00_0002_8000,16'h0000,8'h01,16'h0002,40'h00_0002_8000,3'h0,2'h1},
		'{8'h02,40'h00_0002_8000,16'h0000,8'h01,16'h0003,40'h00_0002_8000,3'h0,2'h1},
		'{8'h80,40'h00_120f_ff00,16'h000c,8'h02,16'h0000,40'h00_0001_20ff,3'h0,2'h0},
		'{8'h00,40'h00_0000_8001,16'h0070,8'h0a,16'h0000,40'h00_8001_0000,3'h0,2'h0},
		'{8'h00,40'h12_3456_789a,16'h0011,8'h02,16'h0000,40'h12_3456_789a,3'h0,2'h0},
		'{8'h00,40'hff_0000_000f,16'hffc4,8'h03,16'h0000,40'hff_f000_0000,3'h0,2'h0},
		'{8'h00,40'h00_0000_0000,16'h008f,8'h04,16'hff8f,40'h00_0000_0000,3'h1,2'h3},
		'{8'h00,40'h00_0000_0000,16'h0000,8'h05,16'hffff,40'h00_0000_0000,3'h1,2'h3},
		'{8'h00,40'h00_0000_0000,16'h1005,8'h04,16'h0005,40'h00_0000_0000,3'h4,2'h3},
		'{8'h00,40'h00_0000_0000,16'h0000,8'h15,16'h00ff,40'h00_0000_0000,3'h4,2'h3},
		'{8'h00,40'h00_0000_0000,16'hff00,8'h04,16'h0000,40'h00_0000_0000,3'h6,2'h3}};
	accum_shift_store_datapath i_accum_shift_store_datapath (.*);
	always #20 core_clk = ~core_clk;
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic expect_eq(input string nm, input logic [39:0] e, input logic [39:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == 2) begin
				s_axi_bready <= w;
				s_axi_rready <= !w;
			end
		end while (!((w ? s_axi_bvalid : s_axi_rvalid) && (s_axi_bready || s_axi_rready))
			&& n < 40);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		q = s_axi_rdata;
		rsp = w ? s_axi_bresp : s_axi_rresp;
		if (n >= 40) begin
			bad_count++;
			give_verdict();
		end
	endtask
	task automatic run_op(input logic [7:0] c);
		bus(1'b1, `REG_CMD, 32'(c));
		repeat (2) @(posedge core_clk);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			rw = rows[i];
			bus(1'b1, `REG_CTRL, 32'(rw.ctrl));
			bus(1'b1, `REG_ACC_A_LO + {rw.cmd[3], 3'b000}, rw.acc[31:0]);
			bus(1'b1, `REG_ACC_A_HI + {rw.cmd[3], 3'b000}, 32'(rw.acc[39:32]));
			bus(1'b1, `REG_OPER, 32'(rw.oper));
			run_op(rw.cmd);
			bus(1'b0, `REG_RESULT, 32'h0000_0000);
			if (rw.chk[0]) expect_eq("result", 40'(rw.res), 40'(q[15:0]));
			bus(1'b0, `REG_STATUS, 32'h0000_0000);
			if (rw.chk[1]) expect_eq("flags", 40'(rw.st), 40'(q[2:0]));
			bus(1'b0, `REG_ACC_A_LO + {rw.cmd[3], 3'b000}, 32'h0000_0000);
			lo = q;
			bus(1'b0, `REG_ACC_A_HI + {rw.cmd[3], 3'b000}, 32'h0000_0000);
			expect_eq("accum", rw.acc_exp, {q[7:0], lo});
			$display("row %0d done", i);
		end
		// Saturating shift of B leaves A alone
		bus(1'b1, `REG_ACC_A_LO, 32'h0000_1234);
		bus(1'b1, `REG_CTRL, 32'h0000_0040);
		bus(1'b1, `REG_ACC_B_LO, 32'h0040_0000);
		bus(1'b1, `REG_ACC_B_HI, 32'h0000_0000);
		bus(1'b1, `REG_OPER, 32'h0000_0076);
		run_op(8'h0a);
		bus(1'b0, `REG_STATUS, 32'h0000_0000);
		expect_eq("sat flag", 40'h00_0000_0001, 40'(q[6]));
		expect_eq("ovf flag", 40'h00_0000_0001, 40'(q[4]));
		bus(1'b0, `REG_ACC_B_LO, 32'h0000_0000);
		lo = q;
		bus(1'b0, `REG_ACC_B_HI, 32'h0000_0000);
		expect_eq("sat accum", 40'h00_7fff_ffff, {q[7:0], lo});
		bus(1'b0, `REG_ACC_A_LO, 32'h0000_0000);
		expect_eq("other accum", 40'h00_0000_1234, 40'(q));
		bus(1'b0, 8'h24, 32'h0000_0000);
		expect_eq("unmapped resp", 40'h00_0000_0002, 40'(rsp));
		bus(1'b1, 8'h24, 32'h0000_0000);
		expect_eq("unmapped write resp", 40'h00_0000_0002, 40'(rsp));
		$display("awkward tests done");
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		bus(1'b0, `REG_CTRL, 32'h0000_0000);
		expect_eq("ctrl after reset", 40'(`CTRL_RESET), 40'(q));
		$display("reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
